// ===== core/etc_checker.sv
// fault and result evaluation for the tracking and eviction leaves
`include "etc_map.svh"
module etc_checker
(
	etc_if.chk chk
);
	import etc_pkg::*;

	logic canon;
	logic limOk;
	logic evType;

	// ****************************************************************
	// check ladder, first failing check wins
	// ****************************************************************
	always_comb
	begin
		canon = (&chk.counter[63:47]) | ~(|chk.counter[63:47]);
		limOk = (chk.counter[31:0] <= chk.segLimit);
		evType = (chk.attr.pageType == ETC_PT_REG) | (chk.attr.pageType == ETC_PT_TCS)
			| (chk.attr.pageType == ETC_PT_TRIM);
		chk.fault = ETC_FAULT_NONE;
		chk.faultAddr = `ETC_RST_WORD;
		chk.acc = `ETC_CODE_OK;
		chk.zf = 1'b0;
		chk.cf = 1'b0;
		chk.evictDone = 1'b0;
		if (chk.attr.cpl != 2'b00)
			chk.fault = ETC_FAULT_GP;
		else if (chk.attr.mode64 && !canon)
			chk.fault = ETC_FAULT_GP;
		else if (chk.attr.protMode && !chk.attr.mode64 && (!limOk
			|| ((chk.leaf == `ETC_LEAF_EVICT) && ((chk.base > chk.segLimit)
			|| (chk.data > chk.segLimit)))))
			chk.fault = ETC_FAULT_GP;
		else if (chk.leaf == `ETC_LEAF_TRACK)
		begin
			if (chk.counter[11:0] != 12'h000)
				chk.fault = ETC_FAULT_GP;
			else if (!chk.attr.regionHit)
			begin
				chk.fault = ETC_FAULT_PF;
				chk.faultAddr = chk.counter[31:0];
			end
			else if (chk.attr.trackBusy)
				chk.fault = ETC_FAULT_GP;
			else if (!chk.attr.mapValid || (chk.attr.pageType != ETC_CONTROL_PAGE_TYPE))
			begin
				chk.fault = ETC_FAULT_PF;
				chk.faultAddr = chk.counter[31:0];
			end
			else if (chk.attr.trackingNz)
			begin
				chk.zf = 1'b1;
				chk.acc = `ETC_CODE_PREV_TRK;
			end
		end
		else if (chk.leaf == `ETC_LEAF_EVICT)
		begin
			if ((chk.base[4:0] != 5'h00) || (chk.counter[11:0] != 12'h000))
				chk.fault = ETC_FAULT_GP;
			else if (!chk.attr.regionHit)
			begin
				chk.fault = ETC_FAULT_PF;
				chk.faultAddr = chk.counter[31:0];
			end
			else if (chk.data[2:0] != 3'h0)
				chk.fault = ETC_FAULT_GP;
			else if (!chk.attr.slotRegion)
			begin
				chk.fault = ETC_FAULT_PF;
				chk.faultAddr = chk.data;
			end
			else if ((chk.counter[31:12] == chk.data[31:12]) || chk.attr.trackBusy)
				chk.fault = ETC_FAULT_GP;
			else if (!chk.attr.mapValid)
			begin
				chk.fault = ETC_FAULT_PF;
				chk.faultAddr = chk.counter[31:0];
			end
			else if (!chk.attr.slotValid || !chk.attr.slotIsVa)
			begin
				chk.fault = ETC_FAULT_PF;
				chk.faultAddr = chk.data;
			end
			else if (evType && !chk.attr.blocked)
			begin
				chk.zf = 1'b1;
				chk.acc = `ETC_CODE_NOT_BLOCK;
			end
			else if (evType && chk.attr.trackRace)
			begin
				chk.zf = 1'b1;
				chk.acc = `ETC_CODE_NOT_TRACK;
			end
			else if ((chk.attr.pageType == ETC_CONTROL_PAGE_TYPE) && chk.attr.childPresent)
			begin
				chk.zf = 1'b1;
				chk.acc = `ETC_CODE_CHILD;
			end
			else
			begin
				chk.evictDone = 1'b1;
				if (chk.attr.slotOccupied)
				begin
					chk.cf = 1'b1;
					chk.acc = `ETC_CODE_SLOT_OCC;
				end
			end
		end
		else
			chk.fault = ETC_FAULT_GP;  // unsupported leaf
	end
endmodule

// ===== core/etc_irq_ctrl.sv
// sticky event status, mask and level interrupt
module etc_irq_ctrl
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic [1:0] evtSet,
	input  wire logic       statusRdClr,
	input  wire logic       maskWr,
	input  wire logic [1:0] maskData,
	output logic      [1:0] status,
	output logic      [1:0] mask,
	output logic            irq
);
	import etc_pkg::*;

	logic [1:0] next_status;
	logic [1:0] next_mask;
	logic       next_irq;

	// set wins over a read-clear in the same cycle
	always_comb
	begin
		next_status = (status & ~{2{statusRdClr}}) | evtSet;
		next_mask = maskWr ? maskData : mask;
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			status <= 2'b00;
			mask <= 2'b00;
			irq <= 1'b0;
		end
		else
		begin
			status <= next_status;
			mask <= next_mask;
			irq <= next_irq;
		end
	end

	irq_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		irq == |(status & mask)) else $error("irq does not follow status and mask");
endmodule

// ===== core/etc_top.sv
// enclave tracking and eviction checker with its AHB-Lite register slave
`include "etc_map.svh"
module etc_top
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	output logic             irq,
	output logic             sealRequest,
	output logic             pageRetire
);
	import etc_pkg::*;

	etc_if req ();

	// ****************************************************************
	// state
	// ****************************************************************
	etc_state_t  state;
	etc_state_t  next_state;
	logic [7:0]  leafCode;
	logic [31:0] cntLo;
	logic [31:0] cntHi;
	logic [31:0] baseAddr;
	logic [31:0] dataAddr;
	logic [17:0] attrBits;
	logic [31:0] segLimit;
	logic [31:0] flags;
	logic [31:0] acc;
	etc_fault_t  faultKind;
	logic [31:0] faultAddr;
	logic [7:0]  wrAddr;
	logic        wrPend;
	logic [7:0]  rdAddr;
	logic        rdPend;
	logic [7:0]  next_leafCode;
	logic [31:0] next_cntLo;
	logic [31:0] next_cntHi;
	logic [31:0] next_baseAddr;
	logic [31:0] next_dataAddr;
	logic [17:0] next_attrBits;
	logic [31:0] next_segLimit;
	logic [31:0] next_flags;
	logic [31:0] next_acc;
	etc_fault_t  next_faultKind;
	logic [31:0] next_faultAddr;
	logic [7:0]  next_wrAddr;
	logic        next_wrPend;
	logic [7:0]  next_rdAddr;
	logic        next_rdPend;
	logic        next_hreadyout;
	logic [31:0] next_hrdata;
	logic        next_sealRequest;
	logic        next_pageRetire;
	logic        addrPhase;
	logic        wrStb;
	logic        statusRdClr;
	logic [1:0]  evtSet;
	logic [1:0]  irqStatus;
	logic [1:0]  irqMask;
	etc_attr_t   attr;

	assign attr = etc_attr_t'(attrBits);

	// ****************************************************************
	// request toward the checker
	// ****************************************************************
	assign req.leaf = leafCode;
	assign req.counter = {cntHi, cntLo};
	assign req.base = baseAddr;
	assign req.data = dataAddr;
	assign req.attr = attr;
	assign req.segLimit = segLimit;

	etc_checker u_checker
	(
		.chk (req)
	);

	// ****************************************************************
	// bus decode
	// ****************************************************************
	assign addrPhase = hsel & htrans[1] & hready;
	assign wrStb = wrPend;
	assign statusRdClr = rdPend & (rdAddr == `ETC_OFS_IRQ_STAT);
	assign evtSet = (state == ETC_ST_POST)
		? {faultKind != ETC_FAULT_NONE, 1'b1} : 2'b00;

	etc_irq_ctrl u_irq
	(
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.evtSet      (evtSet),
		.statusRdClr (statusRdClr),
		.maskWr      (wrStb && (wrAddr == `ETC_OFS_IRQ_MASK)),
		.maskData    (hwdata[1:0]),
		.status      (irqStatus),
		.mask        (irqMask),
		.irq         (irq)
	);

	// read mux, one wait state on every read
	function automatic logic [31:0] readWord(input logic [7:0] a);
		logic [31:0] v;
		v = `ETC_RST_WORD;
		unique case (a)
			`ETC_OFS_CMD:      v = {23'h00_0000, state != ETC_ST_IDLE, leafCode};
			`ETC_OFS_ACC:      v = acc;
			`ETC_OFS_FLAGS:    v = flags;
			`ETC_OFS_FAULT:    v = {30'h0000_0000, faultKind};
			`ETC_OFS_FADDR:    v = faultAddr;
			`ETC_OFS_CNT_LO:   v = cntLo;
			`ETC_OFS_CNT_HI:   v = cntHi;
			`ETC_OFS_BASE:     v = baseAddr;
			`ETC_OFS_DATA:     v = dataAddr;
			`ETC_OFS_ATTR:     v = {14'h0000, attrBits};
			`ETC_OFS_SEGLIM:   v = segLimit;
			`ETC_OFS_IRQ_STAT: v = {30'h0000_0000, irqStatus};
			`ETC_OFS_IRQ_MASK: v = {30'h0000_0000, irqMask};
			default:           v = `ETC_RST_WORD;
		endcase
		return v;
	endfunction

	// ****************************************************************
	// next values: bus slave, operand registers, sequencer
	// ****************************************************************
	always_comb
	begin
		next_wrPend = addrPhase & hwrite;
		next_wrAddr = addrPhase ? haddr[7:0] : wrAddr;
		next_rdPend = addrPhase & ~hwrite;
		next_rdAddr = addrPhase ? haddr[7:0] : rdAddr;
		next_hreadyout = ~(addrPhase & ~hwrite);
		next_hrdata = rdPend ? readWord(rdAddr) : hrdata;
		next_leafCode = leafCode;
		next_cntLo = cntLo;
		next_cntHi = cntHi;
		next_baseAddr = baseAddr;
		next_dataAddr = dataAddr;
		next_attrBits = attrBits;
		next_segLimit = segLimit;
		next_flags = flags;
		next_acc = acc;
		next_faultKind = faultKind;
		next_faultAddr = faultAddr;
		next_state = state;
		next_sealRequest = 1'b0;
		next_pageRetire = 1'b0;
		// operand writes are ignored while an operation runs
		if (wrStb && (state == ETC_ST_IDLE))
		begin
			unique case (wrAddr)
				`ETC_OFS_CMD:
				begin
					next_leafCode = hwdata[7:0];
					next_state = ETC_ST_EVAL;
				end
				`ETC_OFS_FLAGS:  next_flags = hwdata & `ETC_FLAGS_MASK;
				`ETC_OFS_CNT_LO: next_cntLo = hwdata;
				`ETC_OFS_CNT_HI: next_cntHi = hwdata;
				`ETC_OFS_BASE:   next_baseAddr = hwdata;
				`ETC_OFS_DATA:   next_dataAddr = hwdata;
				`ETC_OFS_ATTR:   next_attrBits = hwdata[17:0];
				`ETC_OFS_SEGLIM: next_segLimit = hwdata;
				default:         next_state = state;
			endcase
		end
		unique case (state)
			ETC_ST_IDLE: ;
			ETC_ST_EVAL:
			begin
				next_faultKind = req.fault;
				next_faultAddr = req.faultAddr;
				if (req.fault == ETC_FAULT_NONE)
				begin
					next_acc = req.acc;
					next_flags = `ETC_RST_WORD;
					next_flags[`ETC_FLG_ZF] = req.zf;
					next_flags[`ETC_FLG_CF] = req.cf;
					next_sealRequest = req.evictDone;
					next_pageRetire = req.evictDone;
				end
				next_state = ETC_ST_POST;
			end
			ETC_ST_POST: next_state = ETC_ST_IDLE;
			default:     next_state = ETC_ST_IDLE;
		endcase
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state <= ETC_ST_IDLE;
			leafCode <= 8'h00;
			cntLo <= `ETC_RST_WORD;
			cntHi <= `ETC_RST_WORD;
			baseAddr <= `ETC_RST_WORD;
			dataAddr <= `ETC_RST_WORD;
			attrBits <= 18'h0_0000;
			segLimit <= `ETC_RST_LIMIT;
			flags <= `ETC_RST_WORD;
			acc <= `ETC_RST_WORD;
			faultKind <= ETC_FAULT_NONE;
			faultAddr <= `ETC_RST_WORD;
			wrAddr <= 8'h00;
			wrPend <= 1'b0;
			rdAddr <= 8'h00;
			rdPend <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= `ETC_RST_WORD;
			sealRequest <= 1'b0;
			pageRetire <= 1'b0;
		end
		else
		begin
			state <= next_state;
			leafCode <= next_leafCode;
			cntLo <= next_cntLo;
			cntHi <= next_cntHi;
			baseAddr <= next_baseAddr;
			dataAddr <= next_dataAddr;
			attrBits <= next_attrBits;
			segLimit <= next_segLimit;
			flags <= next_flags;
			acc <= next_acc;
			faultKind <= next_faultKind;
			faultAddr <= next_faultAddr;
			wrAddr <= next_wrAddr;
			wrPend <= next_wrPend;
			rdAddr <= next_rdAddr;
			rdPend <= next_rdPend;
			hreadyout <= next_hreadyout;
			hresp <= 1'b0;
			hrdata <= next_hrdata;
			sealRequest <= next_sealRequest;
			pageRetire <= next_pageRetire;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	logic basicOk;
	assign basicOk = (attr.cpl == 2'b00) && !attr.mode64 && !attr.protMode;

	priv_gp_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == ETC_ST_EVAL) && (attr.cpl != 2'b00) |=> (faultKind == ETC_FAULT_GP))
		else $error("nonzero privilege did not fault");

	canon_gp_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == ETC_ST_EVAL) && (attr.cpl == 2'b00) && attr.mode64
		&& !((&cntHi[31:15]) || !(|cntHi[31:15])) |=> (faultKind == ETC_FAULT_GP))
		else $error("non-canonical operand did not fault");

	limit_gp_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == ETC_ST_EVAL) && (attr.cpl == 2'b00) && attr.protMode && !attr.mode64
		&& (cntLo > segLimit) |=> (faultKind == ETC_FAULT_GP))
		else $error("segment limit overrun did not fault");

	track_align_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == ETC_ST_EVAL) && (leafCode == `ETC_LEAF_TRACK) && basicOk
		&& (cntLo[11:0] != 12'h000) |=> (faultKind == ETC_FAULT_GP))
		else $error("misaligned tracking operand did not fault");

	track_region_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == ETC_ST_EVAL) && (leafCode == `ETC_LEAF_TRACK) && basicOk
		&& (cntLo[11:0] == 12'h000) && !attr.regionHit
		|=> (faultKind == ETC_FAULT_PF) && (faultAddr == $past(cntLo)))
		else $error("tracking operand outside region did not page fault");

	track_busy_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == ETC_ST_EVAL) && (leafCode == `ETC_LEAF_TRACK) && basicOk
		&& (cntLo[11:0] == 12'h000) && attr.regionHit && attr.trackBusy
		|=> (faultKind == ETC_FAULT_GP))
		else $error("busy tracking facility did not fault");

	track_type_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == ETC_ST_EVAL) && (leafCode == `ETC_LEAF_TRACK) && basicOk
		&& (cntLo[11:0] == 12'h000) && attr.regionHit && !attr.trackBusy
		&& (!attr.mapValid || (attr.pageType != ETC_CONTROL_PAGE_TYPE)) |=> (faultKind == ETC_FAULT_PF))
		else $error("invalid or wrong page type did not page fault");

	prev_track_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == ETC_ST_POST) && (leafCode == `ETC_LEAF_TRACK) && (faultKind == ETC_FAULT_NONE)
		|-> (flags[`ETC_FLG_ZF] == attr.trackingNz)
		&& (acc == (attr.trackingNz ? `ETC_CODE_PREV_TRK : `ETC_CODE_OK)))
		else $error("tracking result code or zero flag wrong");

	flags_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == ETC_ST_POST) && (faultKind == ETC_FAULT_NONE) && (leafCode == `ETC_LEAF_TRACK)
		|-> !flags[`ETC_FLG_CF] && !flags[`ETC_FLG_PF] && !flags[`ETC_FLG_AF]
		&& !flags[`ETC_FLG_OF] && !flags[`ETC_FLG_SF])
		else $error("arithmetic flags not cleared");

	seal_pulse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sealRequest |-> pageRetire && (state == ETC_ST_POST) && (acc != `ETC_CODE_NOT_BLOCK)
		##1 !sealRequest)
		else $error("seal request not a single pulse of a good eviction");
endmodule

// ===== shared/etc_if.sv
// request and outcome between the sequencer and the leaf checker
interface etc_if;
	import etc_pkg::*;
	logic [7:0]  leaf;
	logic [63:0] counter;
	logic [31:0] base;
	logic [31:0] data;
	etc_attr_t   attr;
	logic [31:0] segLimit;
	etc_fault_t  fault;
	logic [31:0] faultAddr;
	logic [31:0] acc;
	logic        zf;
	logic        cf;
	logic        evictDone;

	modport seq (output leaf, counter, base, data, attr, segLimit,
		input fault, faultAddr, acc, zf, cf, evictDone);
	modport chk (input leaf, counter, base, data, attr, segLimit,
		output fault, faultAddr, acc, zf, cf, evictDone);
endinterface

// ===== shared/etc_map.svh
// register offsets, field positions, codes and reset values of the enclave checker
`ifndef ETC_MAP_SVH
`define ETC_MAP_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define ETC_OFS_CMD      8'h00
`define ETC_OFS_ACC      8'h04
`define ETC_OFS_FLAGS    8'h08
`define ETC_OFS_FAULT    8'h0C
`define ETC_OFS_FADDR    8'h10
`define ETC_OFS_CNT_LO   8'h14
`define ETC_OFS_CNT_HI   8'h18
`define ETC_OFS_BASE     8'h1C
`define ETC_OFS_DATA     8'h20
`define ETC_OFS_ATTR     8'h24
`define ETC_OFS_SEGLIM   8'h28
`define ETC_OFS_IRQ_STAT 8'h2C
`define ETC_OFS_IRQ_MASK 8'h30
// ****************************************************************
// leaf codes and result codes
// ****************************************************************
`define ETC_LEAF_TRACK      8'h0C
`define ETC_LEAF_EVICT      8'h0B
`define ETC_CODE_OK         32'h0000_0000
`define ETC_CODE_PREV_TRK   32'h0000_0001
`define ETC_CODE_NOT_BLOCK  32'h0000_0002
`define ETC_CODE_NOT_TRACK  32'h0000_0003
`define ETC_CODE_SLOT_OCC   32'h0000_0004
`define ETC_CODE_CHILD      32'h0000_0005
// ****************************************************************
// flag bit positions in the flags register
// ****************************************************************
`define ETC_FLG_CF 0
`define ETC_FLG_PF 2
`define ETC_FLG_AF 4
`define ETC_FLG_ZF 6
`define ETC_FLG_SF 7
`define ETC_FLG_OF 11
`define ETC_FLAGS_MASK 32'h0000_08D5
// ****************************************************************
// interrupt bits and reset values
// ****************************************************************
`define ETC_IRQ_DONE  0
`define ETC_IRQ_FAULT 1
`define ETC_RST_WORD  32'h0000_0000
`define ETC_RST_LIMIT 32'hFFFF_FFFF
`endif

// ===== shared/etc_pkg.sv
// types shared by the enclave checker modules
package etc_pkg;
	`include "etc_map.svh"

	// operation sequencer, gray along idle -> eval -> post
	typedef enum logic [1:0]
	{
		ETC_ST_IDLE = 2'b00,
		ETC_ST_EVAL = 2'b01,
		ETC_ST_POST = 2'b11
	} etc_state_t;

	typedef enum logic [1:0]
	{
		ETC_FAULT_NONE = 2'b00,
		ETC_FAULT_GP   = 2'b01,
		ETC_FAULT_PF   = 2'b10
	} etc_fault_t;

	typedef enum logic [2:0]
	{
		ETC_CONTROL_PAGE_TYPE = 3'h0,
		ETC_PT_REG  = 3'h1,
		ETC_PT_TCS  = 3'h2,
		ETC_PT_VA   = 3'h3,
		ETC_PT_TRIM = 3'h4
	} etc_ptype_t;

	// page state as presented by software in the attribute register
	typedef struct packed
	{
		logic       slotIsVa;      // bit 17
		logic       slotValid;     // bit 16
		logic       slotRegion;    // bit 15
		logic       protMode;      // bit 14
		logic       mode64;        // bit 13
		logic [1:0] cpl;           // bits 12:11
		logic       slotOccupied;  // bit 10
		logic       trackRace;     // bit 9
		logic       trackBusy;     // bit 8
		logic       childPresent;  // bit 7
		logic       trackingNz;    // bit 6
		logic       blocked;       // bit 5
		logic [2:0] pageType;      // bits 4:2
		logic       mapValid;      // bit 1
		logic       regionHit;     // bit 0
	} etc_attr_t;
endpackage

// ===== verif/etc_host_model.sv
// privileged software model issuing leaf operations over the register bus
module etc_host_model
(
	input  wire logic        clk_sys,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// bus idle from time zero
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
	end
	// one word transfer: address held until ready is seen at a rising edge,
	// then data held until ready is seen again; read data taken at that edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		if (wr)
			hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule

// ===== verif/test_enclave_track_and_evict_checker.sv
// self-checking bench for the enclave tracking and eviction checker
`include "etc_map.svh"
module test_enclave_track_and_evict_checker;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        irq;
	logic        sealRequest;
	logic        pageRetire;
	logic [31:0] rdat;
	int          nMismatch = 0;
	int          cmpCount = 0;
	int          nSeal = 0;
	int          cycles = 0;

	always #50 clk_sys = ~clk_sys;

	etc_host_model i_host (.clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));
	etc_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.irq(irq), .sealRequest(sealRequest), .pageRetire(pageRetire));

	task automatic give_verdict();
		$display("mismatches %0d, comparisons %0d", nMismatch, cmpCount);
		if (nMismatch == 0 && cmpCount > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			nMismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, rdat);
	endtask
	task automatic rd(input logic [7:0] a);
		i_host.xfer(1'b0, a, 32'h0000_0000, rdat);
	endtask
	// copy-out pulses come as a pair and are counted
	always @(negedge clk_sys)
	begin
		if (sealRequest !== pageRetire)
			chk({31'h0000_0000, sealRequest}, {31'h0000_0000, pageRetire});
		if (sealRequest === 1'b1)
			nSeal++;
	end
	// hang guard
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			nMismatch++;
			give_verdict();
		end
	end
	// loads operands, starts a leaf, waits for idle and judges the outcome
	task automatic run_op(input logic [7:0] leaf, input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] attr, input logic [31:0] fault, input logic [31:0] acc,
		input logic [31:0] flg, input int seal);
		int n0;
		n0 = nSeal;
		wr(`ETC_OFS_CNT_LO, lo);
		wr(`ETC_OFS_CNT_HI, hi);
		wr(`ETC_OFS_ATTR, attr);
		wr(`ETC_OFS_FLAGS, `ETC_FLAGS_MASK);
		wr(`ETC_OFS_CMD, {24'h00_0000, leaf});
		do rd(`ETC_OFS_CMD); while (rdat[8] !== 1'b0);
		rd(`ETC_OFS_FAULT);
		chk(rdat, fault);
		if (fault == 32'h0000_0002)
		begin
			rd(`ETC_OFS_FADDR);
			chk(rdat, lo);
		end
		if (fault == 32'h0000_0000)
		begin
			rd(`ETC_OFS_ACC);
			chk(rdat, acc);
			rd(`ETC_OFS_FLAGS);
			chk(rdat, flg);
		end
		chk(32'(nSeal - n0), 32'(seal));
	endtask
	task automatic test_reset();
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
		chk({31'h0000_0000, hreadyout}, 32'h0000_0001);
		rd(`ETC_OFS_SEGLIM);
		chk(rdat, `ETC_RST_LIMIT);
		rd(`ETC_OFS_ACC);
		chk(rdat, `ETC_RST_WORD);
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40);
		chk(rdat, 32'h0000_0000);
	endtask
	task automatic test_track();
		run_op(`ETC_LEAF_TRACK, 32'h0000_1000, 0, 32'h0000_0003, 0, 0, 0, 0);
		run_op(`ETC_LEAF_TRACK, 32'h0000_1000, 0, 32'h0000_0043, 0, `ETC_CODE_PREV_TRK,
			32'h0000_0040, 0);
	endtask
	task automatic test_track_faults();
		run_op(`ETC_LEAF_TRACK, 32'h0000_1800, 0, 32'h0000_0000, 1, 0, 0, 0);
		run_op(`ETC_LEAF_TRACK, 32'h0000_2000, 0, 32'h0000_0002, 2, 0, 0, 0);
		run_op(`ETC_LEAF_TRACK, 32'h0000_3000, 0, 32'h0000_0101, 1, 0, 0, 0);
		run_op(`ETC_LEAF_TRACK, 32'h0000_4000, 0, 32'h0000_0001, 2, 0, 0, 0);
		run_op(`ETC_LEAF_TRACK, 32'h0000_5000, 0, 32'h0000_0007, 2, 0, 0, 0);
		run_op(8'h05, 32'h0000_1000, 0, 32'h0000_0003, 1, 0, 0, 0);
	endtask
	task automatic test_mode_faults();
		wr(`ETC_OFS_SEGLIM, 32'h0000_0FFF);
		run_op(`ETC_LEAF_TRACK, 32'h0000_1000, 0, 32'h0000_4003, 1, 0, 0, 0);
		run_op(`ETC_LEAF_TRACK, 32'h0000_0000, 0, 32'h0000_4003, 0, 0, 0, 0);
		wr(`ETC_OFS_SEGLIM, 32'hFFFF_FFFF);
		run_op(`ETC_LEAF_TRACK, 32'h0000_1000, 32'h0001_0000, 32'h0000_2003, 1, 0, 0, 0);
		run_op(`ETC_LEAF_TRACK, 32'h0000_1000, 32'hFFFF_8000, 32'h0000_2003, 0, 0, 0, 0);
	endtask
	task automatic test_evict();
		wr(`ETC_OFS_BASE, 32'h0000_0100);
		wr(`ETC_OFS_DATA, 32'h0000_5008);
		run_op(`ETC_LEAF_EVICT, 32'h0000_3000, 0, 32'h0003_8027, 0, 0, 0, 1);
		run_op(`ETC_LEAF_EVICT, 32'h0000_3000, 0, 32'h0003_8827, 1, 0, 0, 0);
		run_op(`ETC_LEAF_EVICT, 32'h0000_3000, 0, 32'h0003_8007, 0, `ETC_CODE_NOT_BLOCK,
			32'h0000_0040, 0);
		run_op(`ETC_LEAF_EVICT, 32'h0000_3000, 0, 32'h0003_8227, 0, `ETC_CODE_NOT_TRACK,
			32'h0000_0040, 0);
		run_op(`ETC_LEAF_EVICT, 32'h0000_3000, 0, 32'h0003_8427, 0, `ETC_CODE_SLOT_OCC,
			32'h0000_0001, 1);
		run_op(`ETC_LEAF_EVICT, 32'h0000_3000, 0, 32'h0003_80A3, 0, `ETC_CODE_CHILD,
			32'h0000_0040, 0);
	endtask
	task automatic test_irq();
		rd(`ETC_OFS_IRQ_STAT);
		run_op(8'h05, 32'h0000_1000, 0, 32'h0000_0003, 1, 0, 0, 0);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		wr(`ETC_OFS_IRQ_MASK, 32'h0000_0002);
		repeat (2) @(negedge clk_sys);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		rd(`ETC_OFS_IRQ_MASK);
		chk(rdat, 32'h0000_0002);
		rd(`ETC_OFS_IRQ_STAT);
		chk(rdat, 32'h0000_0003);
		repeat (2) @(negedge clk_sys);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		run_op(`ETC_LEAF_TRACK, 32'h0000_1000, 0, 32'h0000_0003, 0, 0, 0, 0);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		rd(`ETC_OFS_IRQ_STAT);
		chk(rdat, 32'h0000_0001);
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		test_reset();
		test_track();
		test_track_faults();
		test_mode_faults();
		test_evict();
		test_irq();
		give_verdict();
	end
endmodule
